// >>> include/alarm_pkg.sv
`default_nettype none
package alarm_pkg;
  // ==========================================================
  // Alarm codes
  localparam logic [11:0] ALM_049 = 12'h049;
  localparam logic [11:0] ALM_04E = 12'h04E;
  localparam logic [11:0] ALM_04F = 12'h04F;
  localparam logic [11:0] ALM_06B = 12'h06B;
  localparam logic [11:0] ALM_080 = 12'h080;
  localparam logic [11:0] ALM_082 = 12'h082;
  localparam logic [11:0] ALM_083 = 12'h083;
  localparam logic [11:0] ALM_084 = 12'h084;
  localparam logic [11:0] ALM_085 = 12'h085;
  localparam logic [11:0] ALM_090 = 12'h090;
  localparam logic [11:0] ALM_091 = 12'h091;
  localparam logic [11:0] ALM_092 = 12'h092;
  localparam logic [11:0] ALM_093 = 12'h093;
  localparam logic [11:0] ALM_0A1 = 12'h0A1;
  localparam logic [11:0] ALM_NONE = 12'h000;

  // ==========================================================
  // Condition slots, lowest index has highest priority
  localparam int NUM_COND = 15;
  localparam int CI_PARAM = 0;
  localparam int CI_ROTARY = 1;
  localparam int CI_MAINT = 2;
  localparam int CI_090 = 3;
  localparam int CI_080 = 4;
  localparam int CI_084 = 5;
  localparam int CI_082 = 6;
  localparam int CI_083 = 7;
  localparam int CI_085 = 8;
  localparam int CI_091 = 9;
  localparam int CI_092 = 10;
  localparam int CI_093 = 11;
  localparam int CI_049 = 12;
  localparam int CI_04E = 13;
  localparam int CI_04F = 14;
  localparam logic [11:0] COND_CODE [NUM_COND] = '{ALM_0A1, ALM_0A1, ALM_06B, ALM_090, ALM_080,
    ALM_084, ALM_082, ALM_083, ALM_085, ALM_091, ALM_092, ALM_093, ALM_049, ALM_04E, ALM_04F};

  // ==========================================================
  // Register map and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COLL_CUR = 8'h08;
  localparam logic [7:0] REG_CNT_TH = 8'h0C;
  localparam logic [7:0] REG_DIST_TH = 8'h10;
  localparam logic [7:0] REG_LIM_POS = 8'h14;
  localparam logic [7:0] REG_LIM_NEG = 8'h18;
  localparam logic [7:0] REG_CNT = 8'h1C;
  localparam logic [7:0] REG_DIST = 8'h20;
  localparam int CTRL_ARST_BIT = 0;
  localparam int CTRL_COLL_EN_BIT = 1;
  localparam int STAT_HELD_BIT = 16;
  localparam logic [15:0] COLL_CUR_RST = 16'hFFFF;
  localparam logic [31:0] THRESH_RST = 32'h00000000;
  localparam logic [31:0] LIM_RST = 32'h00000000;
  localparam logic [7:0] TEACH_MAX_POS = 8'h3F;

  // Condensed code shown on the completed-position bits
  function automatic logic [3:0] simpleCode(input logic [11:0] c);
    logic [3:0] s;
    s = 4'h0;
    if (c >= ALM_090 && c <= ALM_093) s = 4'h2;
    else if (c >= ALM_080 && c <= ALM_085) s = 4'h3;
    else if (c == ALM_0A1) s = 4'h6;
    return s;
  endfunction

  // Message-level alarms lose against all others
  function automatic logic isMessage(input logic [11:0] c);
    return (c == ALM_04E) || (c == ALM_04F);
  endfunction
endpackage
`default_nettype wire

// >>> src/alarm_prio_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_prio_encoder (
  input  wire logic [alarm_pkg::NUM_COND-1:0] cond,
  output logic [11:0]                         code,
  output logic                                valid
);
  import alarm_pkg::*;

  // ==========================================================
  // Fixed-priority pick, lowest slot wins
  always_comb begin
    code = ALM_NONE;
    valid = 1'b0;
    for (int i = NUM_COND - 1; i >= 0; i--) begin
      if (cond[i]) begin
        code = COND_CODE[i];
        valid = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/maint_counter.sv
`timescale 1ns/1ps
`default_nettype none
module maint_counter (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        moveDone,
  input  wire logic [15:0] moveDistance,
  input  wire logic [31:0] countThresh,
  input  wire logic [31:0] distThresh,
  output logic [31:0]      moveCount,
  output logic [31:0]      distTotal,
  output logic             countExceeded,
  output logic             distExceeded
);
  import alarm_pkg::*;

  logic [31:0] moveCount_r;
  logic [31:0] distTotal_r;
  logic [32:0] cntSum;
  logic [32:0] distSum;

  // Saturating sums so the totals never wrap back under a threshold
  assign cntSum = {1'b0, moveCount_r} + 33'h000000001;
  assign distSum = {1'b0, distTotal_r} + {17'h00000, moveDistance};

  // ==========================================================
  // Movement totals
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      moveCount_r <= 32'h00000000;
      distTotal_r <= 32'h00000000;
    end else if (moveDone) begin
      moveCount_r <= cntSum[32] ? 32'hFFFFFFFF : cntSum[31:0];
      distTotal_r <= distSum[32] ? 32'hFFFFFFFF : distSum[31:0];
    end
  end

  // Threshold compare, a zero threshold disables the check
  assign moveCount = moveCount_r;
  assign distTotal = distTotal_r;
  assign countExceeded = (countThresh != THRESH_RST) && (moveCount_r > countThresh);
  assign distExceeded = (distThresh != THRESH_RST) && (distTotal_r > distThresh);
endmodule
`default_nettype wire

// >>> src/actuator_command_alarm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module actuator_command_alarm_checker (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        moveCmd,
  input  wire logic        positionMoveCmd,
  input  wire logic        numericAbsCmd,
  input  wire logic        softResetCmd,
  input  wire logic        teachSelect,
  input  wire logic        current_position_write,
  input  wire logic        servo_on_status,
  input  wire logic        position_complete_status,
  input  wire logic        home_return_done,
  input  wire logic        homingActive,
  input  wire logic        jogActive,
  input  wire logic        teachingMode,
  input  wire logic        positionerMode,
  input  wire logic        simplifiedMode,
  input  wire logic [7:0]  positionNumber,
  input  wire logic        positionValid,
  input  wire logic [7:0]  completedPosition,
  input  wire logic [15:0] motorCurrent,
  input  wire logic        moveDone,
  input  wire logic [15:0] moveDistance,
  input  wire logic        maintDataValid,
  input  wire logic        rotaryAxis,
  input  wire logic        indexToNormal,
  output logic             alarm_out_n,
  output logic [11:0]      alarmCode,
  output logic [7:0]       completed_position_bits
);
  import alarm_pkg::*;

  // ==========================================================
  // Declarations
  logic                wrPend_r;
  logic [7:0]          wrAddr_r;
  logic                collEn_r;
  logic [15:0]         collCur_r;
  logic [31:0]         cntTh_r;
  logic [31:0]         distTh_r;
  logic [31:0]         limPos_r;
  logic [31:0]         limNeg_r;
  logic                cpwPrev_r;
  logic                alarmHeld_r;
  logic [11:0]         alarmCode_r;
  logic                alarmHeld_nxt;
  logic [11:0]         alarmCode_nxt;
  logic [31:0]         readValue;
  logic                addrOk;
  logic                busRead;
  logic                busWrite;
  logic                alarmClear;
  logic                servoReady;
  logic                anyMove;
  logic                cpwRise;
  logic [31:0]         moveCount;
  logic [31:0]         distTotal;
  logic                countExceeded;
  logic                distExceeded;
  logic [NUM_COND-1:0] condVec;
  logic [11:0]         newCode;
  logic                newValid;
  logic                takeNew;

  // ==========================================================
  // AHB-Lite slave, zero wait states
  assign addrOk = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign busRead = hsel && htrans[1] && hready && !hwrite;
  assign busWrite = hsel && htrans[1] && hready && hwrite && addrOk;

  // Capture of the write address phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= busWrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  // Fixed handshake outputs, always ready and OKAY
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    readValue = 32'h00000000;
    if (addrOk) begin
      unique case (haddr[7:0])
        REG_CTRL: readValue = {30'h00000000, collEn_r, 1'b0};
        REG_STATUS: readValue = {15'h0000, alarmHeld_r, 4'h0, alarmCode_r};
        REG_COLL_CUR: readValue = {16'h0000, collCur_r};
        REG_CNT_TH: readValue = cntTh_r;
        REG_DIST_TH: readValue = distTh_r;
        REG_LIM_POS: readValue = limPos_r;
        REG_LIM_NEG: readValue = limNeg_r;
        REG_CNT: readValue = moveCount;
        REG_DIST: readValue = distTotal;
        default: readValue = 32'h00000000;
      endcase
    end
  end

  // Read data registered for the data phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (busRead) begin
      hrdata <= readValue;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      collEn_r <= 1'b0;
      collCur_r <= COLL_CUR_RST;
      cntTh_r <= THRESH_RST;
      distTh_r <= THRESH_RST;
      limPos_r <= LIM_RST;
      limNeg_r <= LIM_RST;
    end else if (wrPend_r) begin
      if (wrAddr_r == REG_CTRL) collEn_r <= hwdata[CTRL_COLL_EN_BIT];
      if (wrAddr_r == REG_COLL_CUR) collCur_r <= hwdata[15:0];
      if (wrAddr_r == REG_CNT_TH) cntTh_r <= hwdata;
      if (wrAddr_r == REG_DIST_TH) distTh_r <= hwdata;
      if (wrAddr_r == REG_LIM_POS) limPos_r <= hwdata;
      if (wrAddr_r == REG_LIM_NEG) limNeg_r <= hwdata;
    end
  end

  // Alarm reset strobe from the control word
  assign alarmClear = wrPend_r && (wrAddr_r == REG_CTRL) && hwdata[CTRL_ARST_BIT];

  // ==========================================================
  // Maintenance totals
  maint_counter u_maint (
    .clk           (clk),
    .reset         (reset),
    .moveDone      (moveDone),
    .moveDistance  (moveDistance),
    .countThresh   (cntTh_r),
    .distThresh    (distTh_r),
    .moveCount     (moveCount),
    .distTotal     (distTotal),
    .countExceeded (countExceeded),
    .distExceeded  (distExceeded)
  );

  // Edge detect of the position write input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpwPrev_r <= 1'b0;
    end else begin
      cpwPrev_r <= current_position_write;
    end
  end

  // ==========================================================
  // Alarm conditions
  assign servoReady = servo_on_status || position_complete_status;
  assign anyMove = moveCmd || positionMoveCmd || numericAbsCmd;
  assign cpwRise = current_position_write && !cpwPrev_r;
  assign condVec[CI_PARAM] = $signed(limNeg_r) > $signed(limPos_r);
  assign condVec[CI_ROTARY] = rotaryAxis && indexToNormal && (limNeg_r == LIM_RST);
  assign condVec[CI_MAINT] = !maintDataValid;
  assign condVec[CI_090] = softResetCmd && servo_on_status;
  assign condVec[CI_080] = anyMove && !servoReady;
  assign condVec[CI_084] = anyMove && homingActive;
  assign condVec[CI_082] = positionMoveCmd && !home_return_done;
  assign condVec[CI_083] = numericAbsCmd && !home_return_done;
  assign condVec[CI_085] = positionerMode && positionMoveCmd && !positionValid;
  assign condVec[CI_091] = teachingMode && teachSelect && (positionNumber > TEACH_MAX_POS);
  assign condVec[CI_092] = cpwRise && jogActive;
  assign condVec[CI_093] = cpwRise && !home_return_done;
  assign condVec[CI_049] = collEn_r && (motorCurrent >= collCur_r);
  assign condVec[CI_04E] = countExceeded;
  assign condVec[CI_04F] = distExceeded;

  alarm_prio_encoder u_prio (
    .cond  (condVec),
    .code  (newCode),
    .valid (newValid)
  );

  // ==========================================================
  // Alarm latch, a new event wins over a reset in the same cycle
  assign takeNew = newValid && (!alarmHeld_r || alarmClear || (isMessage(alarmCode_r) && !isMessage(newCode)));

  always_comb begin
    alarmHeld_nxt = alarmHeld_r;
    alarmCode_nxt = alarmCode_r;
    if (takeNew) begin
      alarmHeld_nxt = 1'b1;
      alarmCode_nxt = newCode;
    end else if (alarmClear) begin
      alarmHeld_nxt = 1'b0;
      alarmCode_nxt = ALM_NONE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alarmHeld_r <= 1'b0;
      alarmCode_r <= ALM_NONE;
    end else begin
      alarmHeld_r <= alarmHeld_nxt;
      alarmCode_r <= alarmCode_nxt;
    end
  end

  // Pin outputs aligned with the latch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alarm_out_n <= 1'b1;
      alarmCode <= ALM_NONE;
      completed_position_bits <= 8'h00;
    end else begin
      alarm_out_n <= !alarmHeld_nxt;
      alarmCode <= alarmCode_nxt;
      if (alarmHeld_nxt && (simplifiedMode || positionerMode)) begin
        completed_position_bits <= {4'h0, simpleCode(alarmCode_nxt)};
      end else begin
        completed_position_bits <= completedPosition;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_collision_code: assert property (
    collEn_r && motorCurrent >= collCur_r && $onehot(condVec) && !alarmHeld_r
    |=> alarmCode == ALM_049 && !alarm_out_n)
    else $error("collision did not raise 049");

  a_servo_off_move: assert property (
    anyMove && !servo_on_status && !position_complete_status && !alarmHeld_r
    && ~|condVec[CI_080-1:0] |=> alarmCode == ALM_080)
    else $error("move with servo off did not raise 080");

  a_homing_move: assert property (
    moveCmd && servoReady && homingActive && !alarmHeld_r && ~|condVec[CI_084-1:0]
    |=> alarmCode == ALM_084)
    else $error("move during homing did not raise 084");

  a_reset_servo_on: assert property (
    softResetCmd && servo_on_status && !alarmHeld_r && ~|condVec[CI_090-1:0]
    |=> alarmCode == ALM_090 ##1 (alarmCode == ALM_090 || $past(alarmClear)))
    else $error("software reset with servo on did not hold 090");

  a_teach_range: assert property (
    teachingMode && teachSelect && positionNumber <= TEACH_MAX_POS |-> !condVec[CI_091])
    else $error("teaching position within range flagged");

  a_write_jogging: assert property (
    $onehot(condVec) && current_position_write && !$past(current_position_write)
    && jogActive && !alarmHeld_r |=> alarmCode == ALM_092)
    else $error("position write while jogging did not raise 092");

  a_write_unhomed: assert property (
    $onehot(condVec) && cpwRise && !home_return_done && !alarmHeld_r
    |=> alarmCode == ALM_093)
    else $error("position write before homing did not raise 093");

  a_limit_order: assert property (
    $signed(limNeg_r) > $signed(limPos_r) && !alarmHeld_r |=> alarmCode == ALM_0A1)
    else $error("soft limit order error did not raise 0A1");

  a_pin_follows: assert property (
    alarm_out_n == (alarmCode == ALM_NONE))
    else $error("alarm pin disagrees with held code");

  a_code_holds: assert property (
    !alarm_out_n && !alarmClear && !newValid |=> $stable(alarmCode) && !alarm_out_n)
    else $error("held alarm code changed without reset");

  a_severe_wins: assert property (
    isMessage(alarmCode) && newValid && !isMessage(newCode) |=> !isMessage(alarmCode))
    else $error("severe alarm did not replace message alarm");

  a_simple_bits: assert property (
    alarmHeld_nxt && positionerMode |=> completed_position_bits == {4'h0, simpleCode(alarmCode)})
    else $error("completed position bits lack condensed code");

  a_position_unhomed: assert property (
    positionMoveCmd && !home_return_done && !alarmHeld_r
    && ~|condVec[CI_082-1:0] |=> alarmCode == ALM_082)
    else $error("position move before homing did not raise 082");

  a_numeric_unhomed: assert property (
    numericAbsCmd && !home_return_done && !alarmHeld_r
    && ~|condVec[CI_083-1:0] |=> alarmCode == ALM_083)
    else $error("numeric move before homing did not raise 083");

  a_counters_lost: assert property (
    !maintDataValid && !alarmHeld_r
    && ~|condVec[CI_MAINT-1:0] |=> alarmCode == ALM_06B)
    else $error("lost maintenance data did not raise 06B");

  c_alarm_raised: cover property (alarm_out_n ##1 !alarm_out_n);
  c_alarm_cleared: cover property (!alarm_out_n ##1 alarm_out_n);
  c_message_replaced: cover property (isMessage(alarmCode) ##1 alarmCode == ALM_0A1);
  c_condensed_shown: cover property (simplifiedMode && !alarm_out_n && completed_position_bits != 8'h00);
  c_reset_while_held: cover property (alarmClear && !alarm_out_n);
endmodule
`default_nettype wire

// >>> tb/host_cmd_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] kind,
  input  wire logic       careless,
  input  wire logic       servoOn,
  input  wire logic       posDone,
  input  wire logic       homeDone,
  input  wire logic       jogging,
  input  wire logic [7:0] posNum,
  output logic            moveCmd,
  output logic            positionMoveCmd,
  output logic            numericAbsCmd,
  output logic            softResetCmd,
  output logic            teachSelect,
  output logic            posWrite
);
  // ==========================================================
  // Status gating of a well-behaved host
  logic       allowed;
  logic [5:0] pulse = 6'h00;

  // A polite host only issues what the status permits
  always_comb begin
    case (kind)
      3'h0, 3'h2: allowed = servoOn || posDone;
      3'h1: allowed = (servoOn || posDone) && homeDone;
      3'h3: allowed = !servoOn;
      3'h4: allowed = (posNum <= 8'h3F);
      default: allowed = homeDone && !jogging;
    endcase
  end

  // One-cycle command after a request; careless mode skips the status check
  always_ff @(posedge clk) begin
    pulse <= (go && (careless || allowed)) ? (6'h01 << kind) : 6'h00;
  end

  // Kind 0..5 maps to one command line each
  assign {posWrite, teachSelect, softResetCmd, numericAbsCmd, positionMoveCmd, moveCmd} = pulse;
endmodule
`default_nettype wire

// >>> tb/actuator_command_alarm_checker_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module actuator_command_alarm_checker_tb_top;
  import alarm_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        go = 1'b0;
  logic [2:0]  kind = 3'h0;
  logic [6:0]  st = 7'h41;
  logic [7:0]  posNum = 8'h00;
  logic        positionerMode = 1'b0;
  logic        simplifiedMode = 1'b0;
  logic        teachingMode = 1'b1;
  logic [7:0]  completedPosition = 8'h00;
  logic [15:0] motorCurrent = 16'h0000;
  logic        moveDone = 1'b0;
  logic [15:0] moveDistance = 16'h0000;
  logic        maintDataValid = 1'b1;
  logic        rotaryAxis = 1'b0;
  logic        indexToNormal = 1'b0;
  logic        moveCmd, positionMoveCmd, numericAbsCmd, softResetCmd, teachSelect, posWrite;
  logic        alarm_out_n;
  logic [11:0] alarmCode;
  logic [7:0]  completed_position_bits;
  logic [15:0] expQ [$];
  logic [11:0] lastCode = 12'h000;
  logic [31:0] dsum = 32'h0;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [7:0]  ra [10] = '{REG_CTRL, REG_STATUS, REG_COLL_CUR, REG_CNT_TH, REG_DIST_TH, REG_LIM_POS,
                           REG_LIM_NEG, REG_CNT, REG_DIST, 8'h24};
  // Kind, {careless,servo,posDone,homed,homing,jog,posValid}, position, code, condensed code
  logic [33:0] tbl [16] = '{
    {3'h0, 7'h41, 8'h00, ALM_080, 4'h3}, {3'h0, 7'h61, 8'h00, ALM_NONE, 4'h0},
    {3'h1, 7'h61, 8'h00, ALM_082, 4'h3}, {3'h2, 7'h61, 8'h00, ALM_083, 4'h3},
    {3'h0, 7'h6D, 8'h00, ALM_084, 4'h3}, {3'h0, 7'h4D, 8'h00, ALM_080, 4'h3},
    {3'h1, 7'h68, 8'h00, ALM_085, 4'h3}, {3'h3, 7'h69, 8'h00, ALM_090, 4'h2},
    {3'h3, 7'h49, 8'h00, ALM_NONE, 4'h0}, {3'h4, 7'h69, 8'h3F, ALM_NONE, 4'h0},
    {3'h4, 7'h69, 8'h40, ALM_091, 4'h2}, {3'h5, 7'h6B, 8'h00, ALM_092, 4'h2},
    {3'h5, 7'h61, 8'h00, ALM_093, 4'h2}, {3'h0, 7'h01, 8'h00, ALM_NONE, 4'h0},
    {3'h0, 7'h51, 8'h00, ALM_NONE, 4'h0}, {3'h4, 7'h69, 8'h40, ALM_NONE, 4'h0}};

  // ==========================================================
  // Clock, design and host model
  initial forever #5 clk = ~clk;

  actuator_command_alarm_checker actuator_command_alarm_checker_i (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .moveCmd(moveCmd), .positionMoveCmd(positionMoveCmd), .numericAbsCmd(numericAbsCmd),
    .softResetCmd(softResetCmd), .teachSelect(teachSelect), .current_position_write(posWrite),
    .servo_on_status(st[5]), .position_complete_status(st[4]), .home_return_done(st[3]),
    .homingActive(st[2]), .jogActive(st[1]), .teachingMode(teachingMode), .positionerMode(positionerMode),
    .simplifiedMode(simplifiedMode), .positionNumber(posNum), .positionValid(st[0]),
    .completedPosition(completedPosition), .motorCurrent(motorCurrent), .moveDone(moveDone),
    .moveDistance(moveDistance), .maintDataValid(maintDataValid), .rotaryAxis(rotaryAxis),
    .indexToNormal(indexToNormal), .alarm_out_n(alarm_out_n), .alarmCode(alarmCode),
    .completed_position_bits(completed_position_bits));

  host_cmd_model host_cmd_model_i (
    .clk(clk), .go(go), .kind(kind), .careless(st[6]), .servoOn(st[5]), .posDone(st[4]),
    .homeDone(st[3]), .jogging(st[1]), .posNum(posNum), .moveCmd(moveCmd),
    .positionMoveCmd(positionMoveCmd), .numericAbsCmd(numericAbsCmd), .softResetCmd(softResetCmd),
    .teachSelect(teachSelect), .posWrite(posWrite));

  // ==========================================================
  // Compare and report
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkAlarm(input logic [15:0] e);
    chkReg({11'h0, alarm_out_n, completed_position_bits, alarmCode}, {16'h0, e});
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Each new held code takes the oldest note; an unannounced code cannot match
  always @(negedge clk) begin
    if (reset === 1'b0 && alarmCode !== lastCode) begin
      if (alarmCode !== ALM_NONE) begin
        chkAlarm(expQ.size() > 0 ? expQ.pop_front() : 16'hFFFF);
      end
      lastCode = alarmCode;
    end
  end

  // ==========================================================
  // Bus and stimulus tasks
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    q = hrdata;
    chkReg({31'h0, hresp}, 32'h0);
  endtask

  task automatic noteAlarm(input logic [11:0] c, input logic [3:0] s);
    if (c !== ALM_NONE) expQ.push_back({s, c});
  endtask

  // Wait for all notes to be met, then check the held code and clear it
  task automatic settle(input logic [11:0] c);
    logic [31:0] q;
    int          i;
    for (i = 0; i < 8 || expQ.size() > 0; i++) begin
      @(posedge clk);
      if (i > 60) begin
        n_fail++;
        wrap_up();
      end
    end
    if (c !== ALM_NONE) begin
      ahb(1'b0, REG_STATUS, 32'h0, q);
      chkReg(q, {15'h0, 1'b1, 4'h0, c});
      ahb(1'b1, REG_CTRL, 32'h1, q);
      ahb(1'b0, REG_STATUS, 32'h0, q);
      chkReg(q, 32'h0);
      chkReg({31'h0, alarm_out_n}, 32'h1);
    end
  endtask

  task automatic fire(input logic [2:0] k, input logic [6:0] s, input logic [7:0] n,
                      input logic [11:0] c, input logic [3:0] sc);
    st <= s;
    posNum <= (k == 3'h4) ? n : 8'($urandom_range(63));
    @(posedge clk);
    noteAlarm(c, sc);
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic moveOnce(input logic [15:0] d);
    moveDistance <= d;
    moveDone <= 1'b1;
    dsum = dsum + {16'h0, d};
    @(posedge clk);
    moveDone <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [33:0] e;
    int          i;
    void'($urandom(32'h17F7));
    @(posedge clk);
    completedPosition <= 8'($urandom());
    motorCurrent <= 16'($urandom_range(255));
    repeat (9) @(posedge clk);
    chkReg({31'h0, alarm_out_n}, 32'h1);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chkReg({24'h0, completed_position_bits}, {24'h0, completedPosition});
    positionerMode <= 1'b1;
    ahb(1'b1, REG_CNT, 32'hFFFFFFFF, q);
    ahb(1'b1, 8'h24, 32'hFFFFFFFF, q);
    for (i = 0; i < 10; i++) begin
      ahb(1'b0, ra[i], 32'h0, q);
      chkReg(q, (ra[i] == REG_COLL_CUR) ? 32'h0000FFFF : 32'h0);
    end
    for (i = 0; i < 16; i++) begin
      e = tbl[i];
      // Alternate the condensed-code modes; the last entry selects outside teaching
      positionerMode <= !i[0];
      simplifiedMode <= i[0];
      teachingMode <= (i != 15);
      fire(e[33:31], e[30:24], e[23:16], e[15:4], e[3:0]);
      settle(e[15:4]);
    end
    // Soft limits compared as signed values
    ahb(1'b1, REG_LIM_NEG, 32'hFFFFFFFC, q);
    ahb(1'b1, REG_LIM_POS, 32'h00000002, q);
    settle(ALM_NONE);
    noteAlarm(ALM_0A1, 4'h6);
    ahb(1'b1, REG_LIM_NEG, 32'h00000003, q);
    ahb(1'b1, REG_LIM_NEG, 32'h00000000, q);
    settle(ALM_0A1);
    // Rotary switch alarms only with a zero negative limit
    rotaryAxis <= 1'b1;
    ahb(1'b1, REG_LIM_NEG, 32'hFFFFFFFC, q);
    indexToNormal <= 1'b1;
    @(posedge clk);
    indexToNormal <= 1'b0;
    settle(ALM_NONE);
    ahb(1'b1, REG_LIM_NEG, 32'h0, q);
    noteAlarm(ALM_0A1, 4'h6);
    indexToNormal <= 1'b1;
    @(posedge clk);
    indexToNormal <= 1'b0;
    settle(ALM_0A1);
    // Lost maintenance data, held after it returns
    noteAlarm(ALM_06B, 4'h0);
    maintDataValid <= 1'b0;
    @(posedge clk);
    maintDataValid <= 1'b1;
    settle(ALM_06B);
    // Collision current at the exact threshold
    ahb(1'b1, REG_COLL_CUR, 32'h100, q);
    motorCurrent <= 16'h00FF;
    ahb(1'b1, REG_CTRL, 32'h2, q);
    settle(ALM_NONE);
    noteAlarm(ALM_049, 4'h0);
    motorCurrent <= 16'h0100;
    @(posedge clk);
    motorCurrent <= 16'($urandom_range(255));
    settle(ALM_049);
    // Movement count over threshold, then replaced by a severe alarm
    ahb(1'b1, REG_CNT_TH, 32'h2, q);
    moveOnce(16'($urandom()));
    moveOnce(16'($urandom()));
    settle(ALM_NONE);
    noteAlarm(ALM_04E, 4'h0);
    moveOnce(16'($urandom()));
    settle(ALM_NONE);
    fire(3'h0, 7'h41, 8'h00, ALM_080, 4'h3);
    ahb(1'b1, REG_CNT_TH, 32'h0, q);
    settle(ALM_080);
    ahb(1'b0, REG_CNT, 32'h0, q);
    chkReg(q, 32'h3);
    ahb(1'b0, REG_DIST, 32'h0, q);
    chkReg(q, dsum);
    // Distance equal to threshold is fine, one more unit is not
    ahb(1'b1, REG_DIST_TH, dsum, q);
    settle(ALM_NONE);
    noteAlarm(ALM_04F, 4'h0);
    moveOnce(16'h0001);
    ahb(1'b1, REG_DIST_TH, 32'h0, q);
    settle(ALM_04F);
    wrap_up();
  end
endmodule
`default_nettype wire
